/* File: cabbo_regs.svh */
// Contract
// [RULE1] add acc and file, route by destination
// [RULE2] add with carry in, route by destination
// [RULE3] shift right, keep msb, lsb to carry
// [RULE4] clear chosen bit, flags untouched
// [RULE5] skip next when tested bit is zero
// [RULE6] pc gets pc plus one plus offset
// [RULE7] branch takes two cycles, flush next
// [RULE8] zero, carry, half carry from result
`ifndef CABBO_REGS_SVH
`define CABBO_REGS_SVH
`define CABBO_DATA_W 8
`define CABBO_PC_W 15
`define CABBO_OFS_W 9
`define CABBO_ADDR_W 7
`define CABBO_RESET_PC 15'h0000
`endif

/* File: cabbo_pkg.sv */
package cabbo_pkg;
  typedef enum logic [2:0] {
    CABBO_OP_NONE,
    CABBO_OP_ADD,
    CABBO_OP_ADDC,
    CABBO_OP_ASR,
    CABBO_OP_BCLR,
    CABBO_OP_BTSZ,
    CABBO_OP_BRA
  } cabbo_op_type;
  typedef struct packed {
    cabbo_op_type op;
    logic dest_file;
    logic [6:0] addr;
    logic [2:0] bit_sel;
    logic [8:0] offset;
  } cabbo_instr_type;
  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic zero;
  } cabbo_flags_type;
  typedef struct packed {
    logic [7:0] value;
    cabbo_flags_type flags;
    logic set_c;
    logic set_dc;
    logic set_z;
  } cabbo_alu_type;
endpackage

/* File: cabbo_alu.sv */
`timescale 1ns/1ps
`include "cabbo_regs.svh"
module cabbo_alu (
  input wire cabbo_pkg::cabbo_op_type op_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] file_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic carry_i,
  output cabbo_pkg::cabbo_alu_type res_o
);
  logic [8:0] sum;
  logic [4:0] low;
  logic cin;
  always_comb begin
    res_o = '0;
    cin = (op_i == cabbo_pkg::CABBO_OP_ADDC) ? carry_i : 1'b0;
    sum = {1'b0, acc_i} + {1'b0, file_i} + {8'h00, cin};
    low = {1'b0, acc_i[3:0]} + {1'b0, file_i[3:0]} + {4'h0, cin};
    case (op_i)
      // [RULE1] plain add
      // [RULE2] carry in added
      cabbo_pkg::CABBO_OP_ADD, cabbo_pkg::CABBO_OP_ADDC: begin
        res_o.value = sum[7:0];
        // [RULE8] flags from sum
        res_o.flags.carry = sum[8];
        res_o.flags.half_carry_flag = low[4];
        res_o.set_c = 1'b1;
        res_o.set_dc = 1'b1;
        res_o.set_z = 1'b1;
      end
      // [RULE3] msb kept, lsb out
      cabbo_pkg::CABBO_OP_ASR: begin
        res_o.value = {file_i[7], file_i[7:1]};
        res_o.flags.carry = file_i[0];
        res_o.set_c = 1'b1;
        res_o.set_z = 1'b1;
      end
      // [RULE4] single bit cleared
      cabbo_pkg::CABBO_OP_BCLR: begin
        res_o.value = file_i & ~(8'h01 << bit_sel_i);
      end
      default: begin
        res_o.value = file_i;
      end
    endcase
    // [RULE8] zero from result
    res_o.flags.zero = (res_o.value == 8'h00);
  end
endmodule // cabbo_alu

/* File: cabbo_core.sv */
`timescale 1ns/1ps
`include "cabbo_regs.svh"
module cabbo_core (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire cabbo_pkg::cabbo_instr_type instr_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic pc_load_i,
  input wire logic [14:0] pc_load_val_i,
  output logic [6:0] file_raddr_o,
  output logic file_we_o,
  output logic [6:0] file_waddr_o,
  output logic [7:0] file_wdata_o,
  output logic [7:0] acc_o,
  output cabbo_pkg::cabbo_flags_type flags_o,
  output logic [14:0] program_counter_o,
  output logic flush_o,
  output logic busy_o
);
  typedef struct packed {
    logic [7:0] acc;
    cabbo_pkg::cabbo_flags_type flags;
    logic [14:0] pc;
    logic flush;
    logic we;
    logic [6:0] waddr;
    logic [7:0] wdata;
  } cabbo_state_type;
  cabbo_state_type state_r;
  cabbo_state_type state_nxt;
  cabbo_pkg::cabbo_alu_type alu;
  logic [14:0] ofs_ext;
  logic take;
  cabbo_alu u_alu (
    .op_i(instr_i.op),
    .acc_i(state_r.acc),
    .file_i(file_rdata_i),
    .bit_sel_i(instr_i.bit_sel),
    .carry_i(state_r.flags.carry),
    .res_o(alu)
  );
  // [RULE6] sign extend offset
  assign ofs_ext = {{(`CABBO_PC_W - `CABBO_OFS_W){instr_i.offset[8]}}, instr_i.offset};
  // second cycle of a skip or branch executes as a no-op
  assign take = instr_valid_i && !state_r.flush;
  always_comb begin
    state_nxt = state_r;
    state_nxt.we = 1'b0;
    state_nxt.flush = 1'b0;
    if (pc_load_i) begin
      state_nxt.pc = pc_load_val_i;
    end else if (instr_valid_i) begin
      state_nxt.pc = state_r.pc + 15'h0001;
    end
    if (take) begin
      case (instr_i.op)
        cabbo_pkg::CABBO_OP_ADD, cabbo_pkg::CABBO_OP_ADDC,
        cabbo_pkg::CABBO_OP_ASR, cabbo_pkg::CABBO_OP_BCLR: begin
          if (alu.set_c) begin
            state_nxt.flags.carry = alu.flags.carry;
          end
          if (alu.set_dc) begin
            state_nxt.flags.half_carry_flag = alu.flags.half_carry_flag;
          end
          if (alu.set_z) begin
            state_nxt.flags.zero = alu.flags.zero;
          end
          // [RULE4] bit clear always to file
          if (instr_i.dest_file || instr_i.op == cabbo_pkg::CABBO_OP_BCLR) begin
            state_nxt.we = 1'b1;
            state_nxt.waddr = instr_i.addr;
            state_nxt.wdata = alu.value;
          end else begin
            state_nxt.acc = alu.value;
          end
        end
        // [RULE5] skip on zero bit
        cabbo_pkg::CABBO_OP_BTSZ: begin
          state_nxt.flush = ~file_rdata_i[instr_i.bit_sel];
        end
        // [RULE6] pc plus one plus k
        // [RULE7] flush fetched word
        cabbo_pkg::CABBO_OP_BRA: begin
          state_nxt.pc = state_r.pc + 15'h0001 + ofs_ext;
          state_nxt.flush = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= '0;
      state_r.pc <= `CABBO_RESET_PC;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign file_raddr_o = instr_i.addr;
  assign file_we_o = state_r.we;
  assign file_waddr_o = state_r.waddr;
  assign file_wdata_o = state_r.wdata;
  assign acc_o = state_r.acc;
  assign flags_o = state_r.flags;
  assign program_counter_o = state_r.pc;
  assign flush_o = state_r.flush;
  assign busy_o = state_r.flush;
endmodule // cabbo_core

/* File: cabbo_core_props.sv */
`timescale 1ns/1ps
module cabbo_core_chk (
  input logic clk_i,
  input logic resetn_i,
  input logic instr_valid_i,
  input cabbo_pkg::cabbo_instr_type instr_i,
  input logic [7:0] file_rdata_i,
  input logic [7:0] file_wdata_o,
  input logic [7:0] acc_o,
  input cabbo_pkg::cabbo_flags_type flags_o,
  input logic [14:0] program_counter_o,
  input logic flush_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // indexed by op code; a flushed slot is never issued
  wire [7:0] hot = {7'h00, instr_valid_i && !flush_o} << instr_i.op;
  wire d = instr_i.dest_file;
  wire [7:0] f = file_rdata_i;
  wire [7:0] s = acc_o + f;
  a_add_acc: assert property (hot[1] && !d |=> acc_o == $past(s))
    else $error("add acc");
  a_add_file: assert property (hot[1] && d |=> file_wdata_o == $past(s))
    else $error("add file");
  a_addc_sum: assert property (hot[2] && !d |=>
    acc_o == $past(s + flags_o.carry)) else $error("addc");
  a_add_flags: assert property (hot[1] |=> flags_o == $past({9'(acc_o) + f > 9'h0FF,
    5'(acc_o[3:0]) + f[3:0] > 5'h0F, s == 8'h00})) else $error("flags");
  a_shift_right: assert property (hot[3] && d |=> flags_o.carry == $past(f[0])
    && file_wdata_o == $past({f[7], f[7:1]})) else $error("asr");
  a_bclr_keep: assert property (hot[4] |=> $stable(flags_o)
    && file_wdata_o == $past(f & ~(8'h01 << instr_i.bit_sel))) else $error("bclr");
  a_skip_zero: assert property (hot[5] |=> flush_o == $past(!f[instr_i.bit_sel]))
    else $error("skip");
  a_branch_pc: assert property (hot[6] |=> flush_o && $stable(flags_o)
    && program_counter_o == $past(program_counter_o + 15'h0001 + 15'(signed'(instr_i.offset))))
    else $error("branch");
  cover property (hot[6]);
  cover property (hot[5] && !f[instr_i.bit_sel]);
  cover property (hot[2]);
endmodule // cabbo_core_chk
bind cabbo_core cabbo_core_chk i_cabbo_core_chk (.*);

/* File: cabbo_tb.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'h0, resetn_i = 1'h0, instr_valid_i = 1'h0, pc_load_i = 1'h0;
  logic file_we_o, flush_o, busy_o;
  logic [6:0] file_raddr_o, file_waddr_o;
  logic [7:0] file_rdata_i = 8'h00, file_wdata_o, acc_o;
  logic [14:0] pc_load_val_i = 15'h0000, program_counter_o, p;
  cabbo_pkg::cabbo_instr_type instr_i = '0;
  cabbo_pkg::cabbo_flags_type flags_o;
  int bad_count = 0, check_count = 0;
  cabbo_core i_cabbo_core (.*);
  initial forever #20 clk_i = ~clk_i;
  task chk(input string n, input logic [14:0] s, e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // o is the op code; k also feeds dest and bit select
  task run(input int o, input logic [8:0] k, input logic [7:0] r);
    @(negedge clk_i);
    instr_valid_i = 1'h1;
    instr_i = '{cabbo_pkg::cabbo_op_type'(o), k[0], 7'h05 ^ 7'(k[2:0]), k[2:0], k};
    file_rdata_i = r;
    #1;
    chk("raddr", file_raddr_o, 7'h05 ^ 7'(k[2:0]));
    @(posedge clk_i);
    #1;
  endtask
  task sc_arith;
    run(1, 9'h000, 8'h7F);
    chk("flags", {flags_o, acc_o}, 11'h07F);
    run(1, 9'h000, 8'h81);
    chk("flags", flags_o, 3'h7);
    run(2, 9'h000, 8'h00);
    chk("acc", acc_o, 8'h01);
    run(1, 9'h001, 8'h0F);
    chk("half carry", {flags_o, file_wdata_o}, 11'h210);
    run(1, 9'h001, 8'hFF);
    chk("wdata", {file_we_o, file_wdata_o}, 9'h100);
    chk("waddr", file_waddr_o, 7'h04);
    run(3, 9'h001, 8'h81);
    chk("asr", {flags_o, file_wdata_o}, 11'h6C0);
  endtask
  task sc_bclr;
    for (int i = 0; i < 8; i++) begin
      run(4, 9'(i), 8'hFF);
      chk("bclr", {flags_o, file_wdata_o}, {3'h6, 8'hFF ^ (8'h01 << i)});
      chk("bclr addr", file_waddr_o, 7'h05 ^ 7'(i));
    end
  endtask
  task sc_flow;
    run(5, 9'h002, 8'hFB);
    chk("skip busy", {flush_o, busy_o}, 2'h3);
    run(1, 9'h000, 8'h10);
    chk("skip", acc_o, 8'h01);
    run(5, 9'h002, 8'h04);
    chk("noskip busy", {flush_o, busy_o}, 2'h0);
    run(1, 9'h000, 8'h10);
    chk("noskip", acc_o, 8'h11);
    p = program_counter_o;
    run(6, 9'h100, 8'h00);
    chk("pc", program_counter_o, p - 15'h00FF);
    chk("branch busy", {flush_o, busy_o}, 2'h3);
    run(1, 9'h000, 8'h10);
    chk("flush", {flush_o, acc_o}, 9'h011);
  endtask
  task sc_load;
    @(negedge clk_i);
    instr_valid_i = 1'h0;
    pc_load_i = 1'h1;
    pc_load_val_i = 15'h1234;
    @(posedge clk_i);
    #1;
    chk("load", program_counter_o, 15'h1234);
    // branch must win over the outside load
    run(6, 9'h0FF, 8'h00);
    chk("override", program_counter_o, 15'h1334);
    @(negedge clk_i);
    pc_load_i = 1'h0;
    instr_valid_i = 1'h0;
  endtask
  task sc_reset;
    @(negedge clk_i);
    resetn_i = 1'h0;
    #1;
    chk("reset", {flags_o, flush_o, busy_o, file_we_o, acc_o}, 14'h0000);
    chk("reset pc", program_counter_o, 15'h0000);
    @(negedge clk_i);
    resetn_i = 1'h1;
    run(1, 9'h000, 8'h23);
    chk("after reset", {flags_o, acc_o}, 11'h023);
    chk("after reset pc", program_counter_o, 15'h0001);
  endtask
  task tally_and_finish;
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    resetn_i = 1'h1;
    sc_arith;
    sc_bclr;
    sc_flow;
    sc_load;
    sc_reset;
    tally_and_finish;
  end
  // about forty cycles of traffic
  initial begin
    repeat (400) @(posedge clk_i);
    bad_count++;
    tally_and_finish;
  end
endmodule // tb_top
